// File: core/ovr_defs.svh
// constants for the over-range status and auxiliary clock output block
`ifndef OVR_DEFS_SVH
`define OVR_DEFS_SVH

`define OVR_SAMPLE_W      12       // width of a channel magnitude sample
`define OVR_PULSE_W       4        // width of the minimum pulse setting
`define OVR_SEL_W         2        // width of a clock source select code
`define OVR_SEL_OFF       2'h0     // no clock, over-range status on the pin
`define OVR_SEL_COPY      2'h1     // undivided reference copy
`define OVR_SEL_DIV2      2'h2     // reference divided by two
`define OVR_SEL_DIV4      2'h3     // reference divided by four
`define OVR_VAR_SINGLE    2'h0     // one-channel variant
`define OVR_VAR_DUAL      2'h1     // two-channel variant
`define OVR_VAR_QUAD      2'h2     // four-channel variant
`define OVR_STRAP_RST     2'h0     // strap latch value while in reset
`define OVR_DIV_CNT_RST   2'h0     // divider counter reset value
`define OVR_PULSE_CNT_RST 4'h0     // stretch counter reset value

`endif

// File: core/ovr_pkg.sv
// types shared by the over-range status and auxiliary clock output block
`include "ovr_defs.svh"

package ovr_pkg;

  // one magnitude sample per channel, a..d
  typedef struct packed {
    logic [`OVR_SAMPLE_W-1:0] a;
    logic [`OVR_SAMPLE_W-1:0] b;
    logic [`OVR_SAMPLE_W-1:0] c;
    logic [`OVR_SAMPLE_W-1:0] d;
  } sample_set_t;

  // register override of the auxiliary clock routing
  typedef struct packed {
    logic                  enable;  // override the straps
    logic [`OVR_SEL_W-1:0] sel_c;   // source for the channel c pin
    logic [`OVR_SEL_W-1:0] sel_d;   // source for the channel d pin
  } clock_override_t;

  // device channel-count variants
  typedef enum logic [1:0] {
    VAR_SINGLE = 2'b00,
    VAR_DUAL   = 2'b01,
    VAR_QUAD   = 2'b10,
    VAR_SPARE  = 2'b11
  } variant_t;

endpackage

// File: core/overrange_stretch.sv
// one channel of over-range compare with minimum pulse stretch
`timescale 1ns/10ps
`include "ovr_defs.svh"

module overrange_stretch (
  input  wire logic                     clk_in,
  input  wire logic                     rst_in,
  input  wire logic                     enable_in,
  input  wire logic [`OVR_SAMPLE_W-1:0] sample_in,
  input  wire logic [`OVR_SAMPLE_W-1:0] threshold_in,
  input  wire logic [`OVR_PULSE_W-1:0]  min_pulse_in,
  output logic                          flag_out
);

  logic                    flag_r;     // registered status
  logic                    flag_nxt;
  logic [`OVR_PULSE_W-1:0] hold_r;     // cycles still to hold after the input drops
  logic [`OVR_PULSE_W-1:0] hold_nxt;
  logic                    beyond;     // sample above threshold

  ////////////////////////////////////////////////////////////////////////////
  // next state: reload the hold count while beyond, then count it down
  always_comb begin
    beyond   = enable_in && (sample_in > threshold_in);
    hold_nxt = hold_r;
    flag_nxt = 1'b0;
    if (!enable_in) begin
      // disabled channel reads low and forgets any pending hold
      hold_nxt = `OVR_PULSE_CNT_RST;
    end else if (beyond) begin
      hold_nxt = min_pulse_in;
      flag_nxt = 1'b1;
    end else if (hold_r != `OVR_PULSE_CNT_RST) begin
      hold_nxt = hold_r - 1'b1;
      flag_nxt = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      flag_r <= 1'b0;
      hold_r <= `OVR_PULSE_CNT_RST;
    end else begin
      flag_r <= flag_nxt;
      hold_r <= hold_nxt;
    end
  end

  assign flag_out = flag_r;

endmodule

// File: core/overrange_status_and_aux_clock_out.sv
// over-range status pins and auxiliary reference clock outputs
`timescale 1ns/10ps
`include "ovr_defs.svh"

module overrange_status_and_aux_clock_out (
  input  wire logic                     clk_in,
  input  wire logic                     rst_in,
  input  wire ovr_pkg::sample_set_t     samples_in,
  input  wire logic [`OVR_SAMPLE_W-1:0] overrange_threshold_in,
  input  wire logic [`OVR_PULSE_W-1:0]  overrange_min_pulse_in,
  input  wire ovr_pkg::variant_t        variant_in,
  input  wire logic [`OVR_SEL_W-1:0]    aux_clock_select_in,
  input  wire ovr_pkg::clock_override_t clock_override_in,
  input  wire logic                     pll_enable_in,
  input  wire logic                     power_down_in,
  input  wire logic                     ref_select_se_in,
  input  wire logic                     ref_clock_diff_in,
  input  wire logic                     ref_clock_se_in,
  output logic                          over_range_out_a,
  output logic                          over_range_out_b,
  output logic                          over_range_out_c,
  output logic                          over_range_out_d,
  output logic                          reference_clock_out,
  output logic                          pll_active_out,
  output logic                          pll_bypass_out,
  output logic                          powered_down_out
);

  import ovr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // timing summary
  //   each input is taken on the rising edge of clk_in, save pll_enable_in and power_down_in on their status pins; there is no handshake
  //   a sample beyond the threshold shows on its pin after the next edge
  //   the stretch keeps the flag up for the pulse setting plus one cycle
  //   the reference pin repeats the selected input one cycle late
  //   the c and d copy levels are registered, so they lag the input by one
  //   cycle as well; the divided levels lag by two, one cycle behind the reference pin
  //
  // pin routing for c and d
  //   override off: the caught straps choose; zero means status on both pins
  //   override off, straps non-zero: d carries the undivided copy only
  //   override on: sel_c and sel_d choose each pin on its own
  //   a d clock is refused unless c clocks too; the pin then sits low
  //   a chosen clock stopped by power-down or pll disable sits low, it does
  //   not fall back to status, so the board never mistakes a stopped clock
  //   for an over-range event
  //
  // power-down
  //   clears every stretch counter and flag, zeroes the reference pin and
  //   parks the divider at zero so the divided copies restart in phase
  //   the pll status pins simply mirror the enable input
  //
  // trade-off
  //   the status path bypasses the pin flop through a registered route bit,
  //   keeping one cycle of latency on all four flags at the cost of a mux
  //   behind the flops on the c and d pins
  //
  // limitations
  //   the reference is oversampled on clk_in, so it must run well below half
  //   the clock rate; faster references alias into a wrong count
  //   straps are caught once after reset; later strap changes need a reset
  //   the spare variant code behaves as the single-channel part
  //   the threshold and pulse setting are shared by all four channels
  //   a pulse setting changed mid-event applies from the next beyond sample

  ////////////////////////////////////////////////////////////////////////////
  // picks a clock level out of the reference and its divided copies
  function automatic logic clock_pick(input logic [`OVR_SEL_W-1:0] sel,
                                      input logic                  ref_lvl,
                                      input logic [1:0]            cnt);
    logic res;
    res = 1'b0;
    case (sel)
      `OVR_SEL_COPY: res = ref_lvl;
      `OVR_SEL_DIV2: res = cnt[0];
      `OVR_SEL_DIV4: res = cnt[1];
      default:       res = 1'b0;
    endcase
    return res;
  endfunction

  // strap latch
  logic [`OVR_SEL_W-1:0] strap_r;       // straps caught after reset release
  logic [`OVR_SEL_W-1:0] strap_nxt;
  logic                  strap_done_r;  // straps have been caught
  logic                  strap_done_nxt;

  // reference repeat and divider
  logic                  ref_level;     // currently selected reference input
  logic                  ref_prev_r;    // reference level one cycle ago
  logic                  ref_prev_nxt;
  logic [1:0]            div_cnt_r;     // free-running reference edge counter
  logic [1:0]            div_cnt_nxt;

  // output routing
  logic                  active;        // pll enabled and not powered down
  logic [`OVR_SEL_W-1:0] sel_c;         // effective channel c source
  logic [`OVR_SEL_W-1:0] sel_d;         // effective channel d source
  logic                  clock_on_c;    // channel c pin carries a clock
  logic                  clock_on_d;    // channel d pin carries a clock
  logic                  en_b;          // channel b detection exists
  logic                  en_cd;         // channel c/d detection exists
  logic                  flag_a;        // stretched status per channel
  logic                  flag_b;
  logic                  flag_c;
  logic                  flag_d;

  // registered pins
  logic                  pin_c_r;
  logic                  pin_c_nxt;
  logic                  pin_d_r;
  logic                  pin_d_nxt;
  logic                  route_c_r;     // pin c shows status, not a clock
  logic                  route_c_nxt;
  logic                  route_d_r;     // pin d shows status, not a clock
  logic                  route_d_nxt;
  logic                  ref_out_r;
  logic                  ref_out_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // straps are caught on the first clock after reset, never by the reset itself
  always_comb begin
    strap_nxt      = strap_r;
    strap_done_nxt = 1'b1;
    if (!strap_done_r) begin
      strap_nxt = aux_clock_select_in;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      strap_r      <= `OVR_STRAP_RST;
      strap_done_r <= 1'b0;
    end else begin
      strap_r      <= strap_nxt;
      strap_done_r <= strap_done_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reference selection and divider; the reference is sampled on clk_in, so
  // it must stay well below half the clock rate to be repeated faithfully
  always_comb begin
    ref_level    = ref_select_se_in ? ref_clock_se_in : ref_clock_diff_in;
    active       = pll_enable_in && !power_down_in;
    ref_prev_nxt = ref_level;
    div_cnt_nxt  = div_cnt_r;
    if (power_down_in) begin
      // counter is cleared and held at zero in power-down so the copies restart in phase
      div_cnt_nxt = `OVR_DIV_CNT_RST;
    end else if (ref_level && !ref_prev_r) begin
      div_cnt_nxt = div_cnt_r + 2'h1;
    end
    ref_out_nxt = active && ref_level;
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ref_prev_r <= 1'b0;
      div_cnt_r  <= `OVR_DIV_CNT_RST;
      ref_out_r  <= 1'b0;
    end else begin
      ref_prev_r <= ref_prev_nxt;
      div_cnt_r  <= div_cnt_nxt;
      ref_out_r  <= ref_out_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-channel detection, gated by the channel-count variant
  always_comb begin
    en_b  = (variant_in == VAR_DUAL) || (variant_in == VAR_QUAD);
    en_cd = (variant_in == VAR_QUAD);
  end

  // channel a exists in every variant; power-down parks it
  overrange_stretch u_stretch_a (
    .clk_in       (clk_in),
    .rst_in       (rst_in),
    .enable_in    (!power_down_in),
    .sample_in    (samples_in.a),
    .threshold_in (overrange_threshold_in),
    .min_pulse_in (overrange_min_pulse_in),
    .flag_out     (flag_a)
  );

  // channel b only in the dual and quad variants
  overrange_stretch u_stretch_b (
    .clk_in       (clk_in),
    .rst_in       (rst_in),
    .enable_in    (!power_down_in && en_b),
    .sample_in    (samples_in.b),
    .threshold_in (overrange_threshold_in),
    .min_pulse_in (overrange_min_pulse_in),
    .flag_out     (flag_b)
  );

  // channels c and d only in the quad variant
  overrange_stretch u_stretch_c (
    .clk_in       (clk_in),
    .rst_in       (rst_in),
    .enable_in    (!power_down_in && en_cd),
    .sample_in    (samples_in.c),
    .threshold_in (overrange_threshold_in),
    .min_pulse_in (overrange_min_pulse_in),
    .flag_out     (flag_c)
  );

  overrange_stretch u_stretch_d (
    .clk_in       (clk_in),
    .rst_in       (rst_in),
    .enable_in    (!power_down_in && en_cd),
    .sample_in    (samples_in.d),
    .threshold_in (overrange_threshold_in),
    .min_pulse_in (overrange_min_pulse_in),
    .flag_out     (flag_d)
  );

  ////////////////////////////////////////////////////////////////////////////
  // source choice for the c and d pins; override wins over the straps
  always_comb begin
    if (clock_override_in.enable) begin
      sel_c = clock_override_in.sel_c;
      sel_d = clock_override_in.sel_d;
    end else begin
      sel_c = strap_r;
      // straps only ever give d the undivided copy
      sel_d = (strap_r != `OVR_SEL_OFF) ? `OVR_SEL_COPY : `OVR_SEL_OFF;
    end
    clock_on_c = active && (sel_c != `OVR_SEL_OFF);
    // d may clock only alongside c, so a lone clock must use c
    clock_on_d = clock_on_c && (sel_d != `OVR_SEL_OFF);
    if (clock_on_c) begin
      pin_c_nxt = clock_pick(sel_c, ref_level, div_cnt_r);
    end else begin
      // clock chosen but stopped by power-down or pll disable: hold low
      pin_c_nxt = 1'b0;
    end
    if (clock_on_d) begin
      pin_d_nxt = clock_pick(sel_d, ref_level, div_cnt_r);
    end else begin
      // a d clock without a c clock is refused and holds the pin low
      pin_d_nxt = 1'b0;
    end
    // a pin with no clock source chosen shows its channel status instead
    route_c_nxt = (sel_c == `OVR_SEL_OFF);
    route_d_nxt = (sel_d == `OVR_SEL_OFF);
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pin_c_r   <= 1'b0;
      pin_d_r   <= 1'b0;
      route_c_r <= 1'b0;
      route_d_r <= 1'b0;
    end else begin
      pin_c_r   <= pin_c_nxt;
      pin_d_r   <= pin_d_nxt;
      route_c_r <= route_c_nxt;
      route_d_r <= route_d_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs; a and b come straight from the stretch flops
  assign over_range_out_a    = flag_a;
  assign over_range_out_b    = flag_b;
  // status goes straight from the stretch flop so c and d share the latency
  // of a and b; the route bit and the clock level are both registered
  assign over_range_out_c    = route_c_r ? flag_c : pin_c_r;
  assign over_range_out_d    = route_d_r ? flag_d : pin_d_r;
  assign reference_clock_out = ref_out_r;
  assign pll_active_out      = pll_enable_in;
  assign pll_bypass_out      = !pll_enable_in;
  assign powered_down_out    = power_down_in;

endmodule

// File: testbench/ovr_props.sv
// concurrent checks on the over-range and aux clock block ports
`timescale 1ns/10ps
`include "ovr_defs.svh"

module ovr_props
  import ovr_pkg::*;
(
  input wire logic                     clk_in,
  input wire logic                     rst_in,
  input wire sample_set_t              samples_in,
  input wire logic [`OVR_SAMPLE_W-1:0] overrange_threshold_in,
  input wire logic [`OVR_PULSE_W-1:0]  overrange_min_pulse_in,
  input wire variant_t                 variant_in,
  input wire clock_override_t          clock_override_in,
  input wire logic                     pll_enable_in,
  input wire logic                     power_down_in,
  input wire logic                     ref_select_se_in,
  input wire logic                     ref_clock_diff_in,
  input wire logic                     ref_clock_se_in,
  input wire logic                     over_range_out_a,
  input wire logic                     over_range_out_b,
  input wire logic                     over_range_out_c,
  input wire logic                     over_range_out_d,
  input wire logic                     reference_clock_out,
  input wire logic                     pll_active_out,
  input wire logic                     pll_bypass_out,
  input wire logic                     powered_down_out
);
  //////////////////////////////////////////////////////////////////
  logic       ref_lvl;     // selected reference level
  logic       ref_gate;    // level the reference pin should show
  logic [4:0] hi_cnt_r;    // high run of flag a
  logic [4:0] hi_cnt_nxt;
  logic [4:0] one_run_r;   // cycles without channel b
  logic [4:0] one_run_nxt;
  clock_override_t ov;
  assign ov = clock_override_in;
  assign ref_lvl = ref_select_se_in ? ref_clock_se_in : ref_clock_diff_in;
  assign ref_gate = ref_lvl & pll_enable_in & ~power_down_in;
  // counters saturate so a long event never wraps into a false fail
  always_comb begin
    hi_cnt_nxt = over_range_out_a ? hi_cnt_r + {4'h0, hi_cnt_r != 5'h1f} : 5'h0;
    one_run_nxt = (variant_in inside {VAR_DUAL, VAR_QUAD}) ? 5'h0 : one_run_r + {4'h0, one_run_r != 5'h1f};
  end
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      hi_cnt_r <= 5'h0;
      one_run_r <= 5'h0;
    end else begin
      hi_cnt_r <= hi_cnt_nxt;
      one_run_r <= one_run_nxt;
    end
  end
  //////////////////////////////////////////////////////////////////
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  flag_rise_a: assert property (samples_in.a > overrange_threshold_in && !power_down_in |=> over_range_out_a)
    else $error("flag a did not rise");
  pulse_width_a: assert property ($fell(over_range_out_a) && !power_down_in && !$past(power_down_in)
    |-> hi_cnt_r > {1'b0, overrange_min_pulse_in}) else $error("flag a pulse too short");
  chan_b_off_a: assert property (one_run_r >= 5'h12 |-> !over_range_out_b)
    else $error("flag b high without channel b");
  copy_c_a: assert property (ov.enable && ov.sel_c == `OVR_SEL_COPY && pll_enable_in && !power_down_in
    |=> over_range_out_c == $past(ref_lvl)) else $error("pin c not a reference copy");
  d_needs_c_a: assert property (ov.enable && ov.sel_c == `OVR_SEL_OFF && ov.sel_d != `OVR_SEL_OFF
    |=> !over_range_out_d) else $error("pin d clocks without c");
  ref_follow_a: assert property (!$past(rst_in) |-> reference_clock_out == $past(ref_gate))
    else $error("reference pin wrong");
  pd_stops_a: assert property (power_down_in |=> !over_range_out_c && !over_range_out_d && !reference_clock_out)
    else $error("clocks run in power-down");
  pll_pins_a: assert property (pll_active_out == pll_enable_in && pll_bypass_out == !pll_enable_in
    && powered_down_out == power_down_in) else $error("pll status pins wrong");
  cover property ($rose(over_range_out_a));
  cover property (ov.enable && ov.sel_c == `OVR_SEL_DIV4 && $rose(over_range_out_c));
  cover property ($rose(power_down_in));
endmodule

// File: testbench/board_side.sv
// far-side board logic: reference sources and pin edge counters
`timescale 1ns/10ps

module board_side (
  input  wire logic  clk_in,
  input  wire logic  clear_in,
  input  wire logic  pin_c_in,
  input  wire logic  pin_d_in,
  input  wire logic  pin_ref_in,
  output logic       ref_diff_out,
  output logic       ref_se_out,
  output logic [7:0] edges_c_out,
  output logic [7:0] edges_d_out,
  output logic [7:0] edges_ref_out
);
  //////////////////////////////////////////////////////////////////
  logic [1:0] phase_r = 2'h0;  // differential ref period 2, single-ended 4
  logic       c_q = 1'b0;
  logic       d_q = 1'b0;
  logic       r_q = 1'b0;
  assign ref_diff_out = phase_r[0];
  assign ref_se_out = phase_r[1];
  // counts rising levels as the board samples them on its own clock
  always @(posedge clk_in) begin
    phase_r <= phase_r + 2'h1;
    {c_q, d_q, r_q} <= {pin_c_in, pin_d_in, pin_ref_in};
    edges_c_out <= clear_in ? 8'h0 : edges_c_out + 8'(pin_c_in & ~c_q);
    edges_d_out <= clear_in ? 8'h0 : edges_d_out + 8'(pin_d_in & ~d_q);
    edges_ref_out <= clear_in ? 8'h0 : edges_ref_out + 8'(pin_ref_in & ~r_q);
  end
endmodule

// File: testbench/tb_overrange_status_and_aux_clock_out.sv
// self-checking bench for the over-range and aux clock block
`timescale 1ns/10ps
`include "ovr_defs.svh"

module tb_overrange_status_and_aux_clock_out;
  import ovr_pkg::*;
  typedef struct packed {variant_t v; logic [11:0] s; logic [3:0] n; logic [3:0] e;} row_t;
  //////////////////////////////////////////////////////////////////
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  sample_set_t smp = '0;
  logic [3:0] npul = 4'h0;
  variant_t vsel = VAR_QUAD;
  logic [1:0] strap = 2'h0;
  clock_override_t ovr = '0;
  logic pll = 1'b1;
  logic pd = 1'b0;  // board keeps power-down low while clocks are needed
  logic se = 1'b0;
  logic clr = 1'b0;
  logic rdiff, rse, oa, ob, oc, od, oref;
  logic [7:0] ec, ed, er;
  int fails = 0;
  int samples_checked = 0;
  int len;
  // threshold 0x64; e holds expected a,b,c,d
  row_t rows [6] = '{'{VAR_QUAD, 12'h065, 4'h2, 4'hf}, '{VAR_QUAD, 12'h064, 4'h2, 4'h0},
    '{VAR_DUAL, 12'hfff, 4'h0, 4'hc}, '{VAR_SINGLE, 12'hfff, 4'hf, 4'h8},
    '{VAR_SPARE, 12'h0c8, 4'h1, 4'h8}, '{VAR_QUAD, 12'hfff, 4'hf, 4'hf}};
  always #4 clk_in = ~clk_in;
  overrange_status_and_aux_clock_out i_dut (.clk_in(clk_in), .rst_in(rst_in), .samples_in(smp),
    .overrange_threshold_in(12'h064), .overrange_min_pulse_in(npul), .variant_in(vsel),
    .aux_clock_select_in(strap), .clock_override_in(ovr), .pll_enable_in(pll), .power_down_in(pd),
    .ref_select_se_in(se), .ref_clock_diff_in(rdiff), .ref_clock_se_in(rse), .over_range_out_a(oa),
    .over_range_out_b(ob), .over_range_out_c(oc), .over_range_out_d(od), .reference_clock_out(oref),
    .pll_active_out(), .pll_bypass_out(), .powered_down_out());
  board_side i_board (.clk_in(clk_in), .clear_in(clr), .pin_c_in(oc), .pin_d_in(od), .pin_ref_in(oref),
    .ref_diff_out(rdiff), .ref_se_out(rse), .edges_c_out(ec), .edges_d_out(ed), .edges_ref_out(er));
  //////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // straps are caught only on the first edge after release
  task automatic do_reset(input logic [1:0] s);
    @(posedge clk_in);
    #1 rst_in = 1'b1;
    strap = s;
    repeat (6) @(posedge clk_in);
    #1 rst_in = 1'b0;
    repeat (3) @(posedge clk_in);
  endtask
  // 64 cycles of edge counting on pins c, d and reference
  task automatic clk_case(input clock_override_t o, input logic p, input logic d, input logic s,
                          input logic [7:0] xc, input logic [7:0] xd, input logic [7:0] xr);
    @(posedge clk_in);
    #1 {ovr, pll, pd, se} = {o, p, d, s};
    repeat (4) @(posedge clk_in);
    #1 clr = 1'b1;
    @(posedge clk_in);
    #1 clr = 1'b0;
    repeat (64) @(posedge clk_in);
    #1 check("edges c", ec, xc);
    check("edges d", ed, xd);
    check("edges ref", er, xr);
    $display("clock case done");
  endtask
  //////////////////////////////////////////////////////////////////
  initial begin
    do_reset(2'h0);
    foreach (rows[i]) begin
      @(posedge clk_in);
      #1 {vsel, npul} = {rows[i].v, rows[i].n};
      smp = {4{rows[i].s}};
      @(posedge clk_in);
      #1 smp = '0;
      check("flags abcd", 8'({oa, ob, oc, od}), 8'(rows[i].e));
      len = 0;
      while (oa === 1'b1) begin
        if (len > 40) begin
          fails++;
          break;
        end
        len++;
        @(posedge clk_in);
        #1;
      end
      check("pulse len a", 8'(len), rows[i].e[3] ? 8'(rows[i].n) + 8'h1 : 8'h0);
      repeat (20) @(posedge clk_in);
      $display("row %0d done", i);
    end
    #1 vsel = VAR_QUAD;
    clk_case('{1'b1, `OVR_SEL_COPY, `OVR_SEL_OFF}, 1'b1, 1'b0, 1'b0, 8'd32, 8'd0, 8'd32);
    clk_case('{1'b1, `OVR_SEL_DIV2, `OVR_SEL_DIV2}, 1'b1, 1'b0, 1'b0, 8'd16, 8'd16, 8'd32);
    clk_case('{1'b1, `OVR_SEL_DIV4, `OVR_SEL_COPY}, 1'b1, 1'b0, 1'b0, 8'd8, 8'd32, 8'd32);
    clk_case('{1'b1, `OVR_SEL_OFF, `OVR_SEL_DIV2}, 1'b1, 1'b0, 1'b0, 8'd0, 8'd0, 8'd32);
    clk_case('{1'b1, `OVR_SEL_COPY, `OVR_SEL_COPY}, 1'b0, 1'b0, 1'b0, 8'd0, 8'd0, 8'd0);
    clk_case('{1'b1, `OVR_SEL_COPY, `OVR_SEL_COPY}, 1'b1, 1'b1, 1'b0, 8'd0, 8'd0, 8'd0);
    clk_case('{1'b1, `OVR_SEL_COPY, `OVR_SEL_OFF}, 1'b1, 1'b0, 1'b1, 8'd16, 8'd0, 8'd16);
    for (int s = 1; s < 4; s++) begin
      do_reset(2'(s));
      clk_case('0, 1'b1, 1'b0, 1'b0, 8'h20 >> (s - 1), 8'd32, 8'd32);
    end
    end_of_test();
  end
endmodule

bind overrange_status_and_aux_clock_out ovr_props i_props (.clk_in, .rst_in, .samples_in,
  .overrange_threshold_in, .overrange_min_pulse_in, .variant_in, .clock_override_in, .pll_enable_in,
  .power_down_in, .ref_select_se_in, .ref_clock_diff_in, .ref_clock_se_in, .over_range_out_a,
  .over_range_out_b, .over_range_out_c, .over_range_out_d, .reference_clock_out, .pll_active_out,
  .pll_bypass_out, .powered_down_out);
